//--- logic/ssf_defs.svh
`ifndef SSF_DEFS_SVH
`define SSF_DEFS_SVH

// Buffer geometry
`define SSF_DEPTH 512
`define SSF_PTR_W 9
`define SSF_CNT_W 10
`define SSF_MAX_FRAME 9

// Frame header fields
`define SSF_HDR_SENSOR 8'h80
`define SSF_HDR_TIME 8'ha0
`define SSF_HDR_EMPTY 8'h80
`define SSF_HDR_TIME_BIT 5
`define SSF_HDR_TEMP_BIT 4
`define SSF_HDR_PRESS_BIT 2
`define SSF_EMPTY_DATA 8'h00
`define SSF_TIME_FRAME_LEN 3'h4
`define SSF_EMPTY_FRAME_LEN 3'h2
`define SSF_HDR_LEN 3'h1
`define SSF_CHAN_LEN 3'h3

// Source select code for filtered results
`define SSF_SRC_FILTERED 2'h1

// Command codes
`define SSF_CMD_FLUSH 8'hb0
`define SSF_CMD_SOFTRESET 8'hb6

// Count register layout
`define SSF_CNT_HIGH_BIT 8

`endif

//--- logic/ssf_pkg.sv
`default_nettype none

package ssf_pkg;

  typedef enum logic [1:0] {
    SSF_KIND_DATA,
    SSF_KIND_TIME,
    SSF_KIND_EMPTY
  } ssf_kind_t;

endpackage : ssf_pkg

`default_nettype wire

//--- logic/ssf_fifo_input.sv
// How it works
// [R1] A 512-byte first-in-first-out buffer holds measurement frames.
// [R2] Writing is off when master enable is 0 or both channel enables are 0.
// [R3] With writing off, no frames are added; held frames stay readable and flushable.
// [R4] The full flag keeps being evaluated while writing is off.
// [R5] After stored bytes run out, a time frame (if enabled) then empty frames follow.
// [R6] Pressure and temperature storage are enabled independently, any combination.
// [R7] Source select 01 stores filtered results; any other value stores unfiltered.
// [R8] Byte count: bit 8 in high register bit 0, bits 7:0 in low register.
// [R9] Count rises only once a whole frame is written and readable.
// [R10] Count falls each time a whole frame has been read out.
// [R11] Count moves by whole frame lengths; partial frames never show.
// [R12] Sensor header is 1,0,time,temp,0,press,0,0 followed by 3-byte channel data.
// [R13] Buffer is full when free space is below nine bytes.
// [R14] An empty buffer returns a header without flags and a zero byte.
// [R15] Command 0xb0 or 0xb6 discards every stored frame.
// [R16] A frame is staged and committed in one cycle with pointer and count.
// [R17] Count reads zero after reset or purge; high register upper bits read zero.
`timescale 1ns/10ps
`default_nettype none
`include "ssf_defs.svh"

module ssf_sync2 #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic pin,
  output logic synced
);

  logic first;

  // Only the second flop is read onward, so a metastable first stage stays contained
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      first <= RESET_LEVEL;
      synced <= RESET_LEVEL;
    end else begin
      first <= pin;
      synced <= first;
    end
  end

endmodule : ssf_sync2

module ssf_frame_len (
  input wire logic temp_present,
  input wire logic press_present,
  output logic [2:0] len
);

  // Header byte plus three bytes for each channel present
  assign len = `SSF_HDR_LEN + (temp_present ? `SSF_CHAN_LEN : 3'h0)
             + (press_present ? `SSF_CHAN_LEN : 3'h0);

endmodule : ssf_frame_len

module ssf_fifo_input (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic store_enable,
  input wire logic store_press_enable,
  input wire logic store_temp_enable,
  input wire logic [1:0] source_select,
  input wire logic time_frame_enable,
  input wire logic meas_valid,
  input wire logic [23:0] temp_unfiltered,
  input wire logic [23:0] press_unfiltered,
  input wire logic [23:0] temp_filtered,
  input wire logic [23:0] press_filtered,
  input wire logic [23:0] sensor_time,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic burst_sel_n,
  input wire logic burst_sck,
  output logic [7:0] read_byte,
  output logic [7:0] buffered_byte_count_low,
  output logic [7:0] buffered_byte_count_high,
  output logic buffer_full,
  output logic write_active
);

  logic [7:0] mem [`SSF_DEPTH];
  logic [7:0] next_mem [`SSF_DEPTH];
  logic [`SSF_PTR_W-1:0] wr_ptr, next_wr_ptr;
  logic [`SSF_PTR_W-1:0] rd_ptr, next_rd_ptr;
  logic [`SSF_CNT_W-1:0] count, next_count;
  logic [7:0] next_read_byte;
  logic [2:0] byte_idx, next_byte_idx;
  ssf_pkg::ssf_kind_t kind, next_kind;
  logic time_sent, next_time_sent;
  logic [23:0] time_latch, next_time_latch;

  // Link pins cross into clk through two flops before any logic looks at them
  logic sck_s, sck_d, sel_s;

  ssf_sync2 #(.RESET_LEVEL(1'b0)) sck_sync (
    .clk(clk),
    .arst_n(arst_n),
    .pin(burst_sck),
    .synced(sck_s)
  );

  ssf_sync2 #(.RESET_LEVEL(1'b1)) sel_sync (
    .clk(clk),
    .arst_n(arst_n),
    .pin(burst_sel_n),
    .synced(sel_s)
  );

  // Edge history rests at the idle low level of the pin, so reset makes no false edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_d <= 1'b0;
    end else begin
      sck_d <= sck_s;
    end
  end

  logic in_burst, sck_rise;
  assign in_burst = ~sel_s;
  assign sck_rise = sck_s & ~sck_d;

  // Write side
  logic wr_on, flush, fits;
  logic [2:0] wr_len;
  logic [7:0] wr_hdr;
  logic [23:0] t_sel, p_sel;
  logic [`SSF_CNT_W-1:0] free_space;
  logic [7:0] stage [7];

  ssf_frame_len wr_len_calc (
    .temp_present(store_temp_enable),
    .press_present(store_press_enable),
    .len(wr_len)
  );

  assign wr_on = store_enable & (store_press_enable | store_temp_enable); // [R2] [R6]
  assign write_active = wr_on;
  assign flush = cmd_valid & ((cmd_code == `SSF_CMD_FLUSH) | (cmd_code == `SSF_CMD_SOFTRESET)); // [R15]
  assign t_sel = (source_select == `SSF_SRC_FILTERED) ? temp_filtered : temp_unfiltered; // [R7]
  assign p_sel = (source_select == `SSF_SRC_FILTERED) ? press_filtered : press_unfiltered; // [R7]
  assign free_space = `SSF_CNT_W'(`SSF_DEPTH) - count;
  assign buffer_full = free_space < `SSF_CNT_W'(`SSF_MAX_FRAME); // [R13] [R4]
  // Full frames are dropped here; this is the only overflow policy
  assign fits = ~buffer_full;

  always_comb begin
    wr_hdr = `SSF_HDR_SENSOR; // [R12]
    wr_hdr[`SSF_HDR_TEMP_BIT] = store_temp_enable;
    wr_hdr[`SSF_HDR_PRESS_BIT] = store_press_enable;
    for (int i = 0; i < 7; i++) begin
      stage[i] = 8'h00;
    end
    // [R16] Staged image of the whole frame, least significant byte first
    stage[0] = wr_hdr;
    if (store_temp_enable) begin
      stage[1] = t_sel[7:0];
      stage[2] = t_sel[15:8];
      stage[3] = t_sel[23:16];
      stage[4] = p_sel[7:0];
      stage[5] = p_sel[15:8];
      stage[6] = p_sel[23:16];
    end else begin
      stage[1] = p_sel[7:0];
      stage[2] = p_sel[15:8];
      stage[3] = p_sel[23:16];
    end
  end

  // Read side
  logic [7:0] head_byte, cur_byte;
  logic [2:0] data_len, cur_len;
  ssf_pkg::ssf_kind_t cur_kind;
  logic frame_done, commit;

  assign head_byte = mem[rd_ptr];
  ssf_frame_len rd_len_calc (
    .temp_present(head_byte[`SSF_HDR_TEMP_BIT]),
    .press_present(head_byte[`SSF_HDR_PRESS_BIT]),
    .len(data_len)
  );

  always_comb begin
    // Frame kind is chosen at each frame start and held until it ends
    if (byte_idx != 3'h0) begin
      cur_kind = kind;
    end else if (count != '0) begin
      cur_kind = ssf_pkg::SSF_KIND_DATA;
    end else if (time_frame_enable && !time_sent) begin
      cur_kind = ssf_pkg::SSF_KIND_TIME; // [R5]
    end else begin
      cur_kind = ssf_pkg::SSF_KIND_EMPTY; // [R5] [R14]
    end
    unique case (cur_kind)
      ssf_pkg::SSF_KIND_DATA: begin
        cur_len = data_len;
        cur_byte = mem[rd_ptr + `SSF_PTR_W'(byte_idx)];
      end
      ssf_pkg::SSF_KIND_TIME: begin
        cur_len = `SSF_TIME_FRAME_LEN;
        unique case (byte_idx)
          3'h0: cur_byte = `SSF_HDR_TIME;
          3'h1: cur_byte = time_latch[7:0];
          3'h2: cur_byte = time_latch[15:8];
          default: cur_byte = time_latch[23:16];
        endcase
      end
      default: begin
        cur_len = `SSF_EMPTY_FRAME_LEN;
        cur_byte = (byte_idx == 3'h0) ? `SSF_HDR_EMPTY : `SSF_EMPTY_DATA; // [R14]
      end
    endcase
  end

  assign frame_done = in_burst & sck_rise & (byte_idx == cur_len - 3'h1);
  assign commit = meas_valid & wr_on & fits; // [R3]

  always_comb begin
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    next_read_byte = read_byte;
    next_byte_idx = byte_idx;
    next_kind = kind;
    next_time_sent = time_sent;
    next_time_latch = time_latch;
    if (commit) begin
      for (int i = 0; i < 7; i++) begin
        if (3'(i) < wr_len) begin
          next_mem[wr_ptr + `SSF_PTR_W'(i)] = stage[i]; // [R1] [R16]
        end
      end
      // Pointer wraps at the buffer end by its own width, so no compare is needed
      next_wr_ptr = wr_ptr + `SSF_PTR_W'(wr_len); // [R16]
    end
    // [R9] [R10] [R11] Count moves only on whole-frame commit, whole-frame read and flush
    next_count = count + (commit ? `SSF_CNT_W'(wr_len) : '0)
               - ((frame_done && cur_kind == ssf_pkg::SSF_KIND_DATA) ? `SSF_CNT_W'(cur_len) : '0);
    if (in_burst && sck_rise) begin
      next_read_byte = cur_byte;
      next_kind = cur_kind;
      if (byte_idx == 3'h0 && cur_kind == ssf_pkg::SSF_KIND_TIME) begin
        next_time_latch = sensor_time;
      end
      if (frame_done) begin
        next_byte_idx = 3'h0;
        if (cur_kind == ssf_pkg::SSF_KIND_DATA) begin
          next_rd_ptr = rd_ptr + `SSF_PTR_W'(cur_len); // [R10]
        end
        if (cur_kind == ssf_pkg::SSF_KIND_TIME) begin
          next_time_sent = 1'b1;
        end
      end else begin
        next_byte_idx = byte_idx + 3'h1;
      end
    end
    if (!in_burst) begin
      // A frame cut short is sent again whole on the next burst
      next_byte_idx = 3'h0;
      next_time_sent = 1'b0;
    end
    // Flush outranks a commit in the same cycle, so a purge always leaves zero
    if (flush) begin
      next_wr_ptr = '0; // [R15] [R17]
      next_rd_ptr = '0;
      next_count = '0;
      next_byte_idx = 3'h0;
    end
    if (next_byte_idx == 3'h0 && !in_burst) begin
      next_kind = ssf_pkg::SSF_KIND_EMPTY;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `SSF_DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0; // [R17]
      read_byte <= 8'h00;
      byte_idx <= 3'h0;
      kind <= ssf_pkg::SSF_KIND_EMPTY;
      time_sent <= 1'b0;
      time_latch <= 24'h000000;
    end else begin
      mem <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      read_byte <= next_read_byte;
      byte_idx <= next_byte_idx;
      kind <= next_kind;
      time_sent <= next_time_sent;
      time_latch <= next_time_latch;
    end
  end

  assign buffered_byte_count_low = count[7:0]; // [R8]
  assign buffered_byte_count_high = {7'h00, count[`SSF_CNT_HIGH_BIT]}; // [R8] [R17]

endmodule : ssf_fifo_input

`default_nettype wire

//--- verification/ssf_fifo_input_checker.sv
`timescale 1ns/10ps
`default_nettype none
module ssf_fifo_input_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic store_enable,
  input wire logic store_press_enable,
  input wire logic store_temp_enable,
  input wire logic meas_valid,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic burst_sel_n,
  input wire logic [7:0] buffered_byte_count_low,
  input wire logic [7:0] buffered_byte_count_high,
  input wire logic buffer_full,
  input wire logic write_active
);
  logic [9:0] cnt;
  logic [9:0] len;
  assign cnt = {1'b0, buffered_byte_count_high[0], buffered_byte_count_low};
  assign len = 10'd1 + (store_temp_enable ? 10'd3 : 10'd0) + (store_press_enable ? 10'd3 : 10'd0);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  hi_bits_zero_a: assert property (buffered_byte_count_high[7:1] == 7'h0)
    else $error("high count spare bits set");
  full_level_a: assert property (buffer_full == (10'd512 - cnt < 10'd9))
    else $error("full flag disagrees with count");
  write_gate_a: assert property (write_active == (store_enable && (store_press_enable || store_temp_enable)))
    else $error("write enable gating wrong");
  // Four idle samples of the select pin leave no pop in flight
  commit_step_a: assert property (burst_sel_n[*4] ##0 (meas_valid && write_active && !buffer_full && !cmd_valid) |=> cnt == $past(cnt) + $past(len))
    else $error("commit did not add frame length");
  purge_zero_a: assert property (cmd_valid && (cmd_code == 8'hb0 || cmd_code == 8'hb6) |=> cnt == 10'd0)
    else $error("purge left bytes");
  hold_off_a: assert property (burst_sel_n[*4] ##0 (!write_active && !cmd_valid) |=> $stable(cnt))
    else $error("count moved while writing off");
  pop_whole_a: assert property (!write_active && !cmd_valid |=> $stable(cnt) || $past(cnt) - cnt == 10'd4 || $past(cnt) - cnt == 10'd7)
    else $error("count fell by a partial frame");
  full_drop_a: assert property (burst_sel_n[*4] ##0 (meas_valid && buffer_full && !cmd_valid) |=> $stable(cnt))
    else $error("frame stored while full");
  cover property (meas_valid && write_active ##1 cnt != 10'd0);
  cover property (buffer_full);
  cover property (!burst_sel_n ##1 $fell(cnt[2]));
endmodule : ssf_fifo_input_checker
bind ssf_fifo_input ssf_fifo_input_checker chk (.clk(clk), .arst_n(arst_n),
  .store_enable(store_enable), .store_press_enable(store_press_enable),
  .store_temp_enable(store_temp_enable), .meas_valid(meas_valid), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .burst_sel_n(burst_sel_n), .write_active(write_active),
  .buffered_byte_count_low(buffered_byte_count_low), .buffer_full(buffer_full),
  .buffered_byte_count_high(buffered_byte_count_high));
`default_nettype wire

//--- verification/ssf_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module ssf_host_model (
  output logic sel_n,
  output logic sck
);
  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
  end
  // Clock rests low outside bursts; select leads the first edge by six clocks
  task automatic burst(input int n);
    sel_n = 1'b0;
    #24;
    repeat (n) begin
      sck = 1'b1;
      #24;
      sck = 1'b0;
      #24;
    end
    sel_n = 1'b1;
  endtask : burst
endmodule : ssf_host_model
`default_nettype wire

//--- verification/tb_sensor_sample_fifo_input.sv
`timescale 1ns/10ps
`default_nettype none
module tb_sensor_sample_fifo_input;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic se, pe, te, tfe, mv, cv;
  logic [1:0] src;
  logic [7:0] cc, rb, cl, ch;
  logic [23:0] tu, pu, tf, pf, st;
  wire logic sel_n, sck, full, wa;
  wire logic [9:0] cnt = {ch[1:0], cl};
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int seed = 32'h8630;
  int exp_cnt = 0;
  logic [7:0] exp[$];
  always #2 clk = ~clk;
  ssf_host_model host (.sel_n(sel_n), .sck(sck));
  ssf_fifo_input dut (.clk(clk), .arst_n(arst_n), .store_enable(se), .store_press_enable(pe),
    .store_temp_enable(te), .source_select(src), .time_frame_enable(tfe), .meas_valid(mv),
    .temp_unfiltered(tu), .press_unfiltered(pu), .temp_filtered(tf), .press_filtered(pf),
    .sensor_time(st), .cmd_valid(cv), .cmd_code(cc), .burst_sel_n(sel_n), .burst_sck(sck),
    .read_byte(rb), .buffered_byte_count_low(cl), .buffered_byte_count_high(ch),
    .buffer_full(full), .write_active(wa));
  task automatic check(input logic [9:0] got, input logic [9:0] want);
    check_count++;
    if (got !== want) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, want);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic meas(input logic [1:0] s);
    logic [23:0] t, p;
    {tu, pu, tf, pf} = {24'($random(seed)), 24'($random(seed)), 24'($random(seed)), 24'($random(seed))};
    src = s;
    t = s == 2'h1 ? tf : tu;
    p = s == 2'h1 ? pf : pu;
    mv = 1'b1;
    if (se && (te || pe) && exp_cnt < 504) begin
      exp.push_back({3'b100, te, 1'b0, pe, 2'b00});
      for (int b = 0; b < 3 && te; b++) exp.push_back(t[8*b+:8]);
      for (int b = 0; b < 3 && pe; b++) exp.push_back(p[8*b+:8]);
      exp_cnt += 1 + 3 * (te + pe);
    end
    @(negedge clk);
    mv = 1'b0;
    check(cnt, exp_cnt[9:0]);
    @(negedge clk);
  endtask : meas
  task automatic cmd(input logic [7:0] c);
    cv = 1'b1;
    cc = c;
    if (c == 8'hb0 || c == 8'hb6) begin
      exp_cnt = 0;
      exp.delete();
    end
    @(negedge clk);
    cv = 1'b0;
    check(cnt, exp_cnt[9:0]);
    @(negedge clk);
  endtask : cmd
  always @(negedge sck)
    if (!sel_n) check({2'b00, rb}, exp.size() ? {2'b00, exp.pop_front()} : 10'h3ff);
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    int n;
    {se, pe, te, tfe, mv, cv, src, cc, tu, pu, tf, pf, st} = '0;
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    check(cnt, 10'd0);
    se = 1'b1;
    for (int i = 0; i < 8; i++) begin
      {pe, te} = 2'(i);
      meas(i[2] ? 2'h1 : 2'(i));
    end
    se = 1'b0;
    meas(2'h1);
    tfe = 1'b1;
    st = 24'($random(seed));
    n = exp_cnt + 8;
    exp.push_back(8'ha0);
    for (int b = 0; b < 3; b++) exp.push_back(st[8*b+:8]);
    repeat (2) exp.push_back(8'h80);
    exp.insert(exp.size() - 1, 8'h00);
    exp.push_back(8'h00);
    host.burst(n);
    repeat (4) @(negedge clk);
    exp_cnt = 0;
    check(cnt, 10'd0);
    se = 1'b1;
    {pe, te} = 2'b11;
    repeat (74) meas(2'($random(seed)));
    se = 1'b0;
    check({9'h0, full}, 10'd1);
    cmd(8'h55);
    cmd(8'hb0);
    se = 1'b1;
    meas(2'h0);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    exp_cnt = 0;
    exp.delete();
    check(cnt, 10'd0);
    meas(2'h0);
    cmd(8'hb6);
    give_verdict();
  end
endmodule : tb_sensor_sample_fifo_input
`default_nettype wire
